// file: verilog/rtc_timer_alarm_core.sv
/*
  Timer, capture/preload bank, alarm bank and oscillator control register,
  reached through an indirect address/data register pair.
  Assumes all inputs are synchronous to REF_CLK and that the interrupt
  enable and reset-source enable live elsewhere in the chip.
*/
// How it works
// [R1] timer adds one each clock while run bit is set, else holds
// [R2] load and snapshot work while the timer keeps counting
// [R3] preload value sits in capture bank bits 47..1, bit 0 ignored
// [R4] writing one to set bit copies capture bank into the timer
// [R5] set bit clears itself when the preload is done; software polls it
// [R6] writing one to capture bit copies timer into capture bits 47..1
// [R7] capture bit clears itself once the snapshot is stored
// [R8] timer is compared every cycle against alarm bank bits 47..1, bit 0 ignored
// [R9] alarm event fires on timer greater than or equal to alarm
// [R10] alarm event requests an interrupt when the interrupt is enabled
// [R11] alarm event requests a chip reset when enabled as reset source
// [R12] every alarm event raises a wake-up request for the oscillator
// [R13] software disables alarm, writes alarm bank, then re-enables alarm
// [R14] software clears flag and sets alarm bank to maximum after service
// [R15] read-only status bit shows backup supply (1) or main supply (0)
// [R16] oscillator register: gain, mode, bias r/w; clock-valid, backup read-only
// [R17] alarm flag stays set until software clears it
// [R18] timer wraps from all ones to zero and keeps counting
module rtc_timer_alarm_core (
  // clock, reset, enable
  input  wire logic            REF_CLK,
  input  wire logic            SRST,
  input  wire logic            CE,
  // processor access
  input  wire rtc_pkg::rtc_req_s CPU_REQ,
  output logic [7:0]           ADR_Q,
  output logic [7:0]           RDATA,
  // chip-level enables and status
  input  wire logic            IRQ_EN,
  input  wire logic            RST_SRC_EN,
  input  wire logic            OSC_VALID,
  input  wire logic            BACKUP_PWR,
  // requests
  output logic                 IRQ,
  output logic                 RST_REQ,
  output logic                 WAKE_REQ,
  // oscillator settings
  output logic                 GAIN_CTRL_EN,
  output logic                 XTAL_MODE,
  output logic                 BIAS_DOUBLE
);
  import rtc_pkg::*;

  // ===========================================
  // state
  logic [TIMER_W-1:0] timer_r;
  logic [TIMER_W-1:0] timer_nxt;
  logic [BANK_W-1:0]  cap_r;
  logic [BANK_W-1:0]  alm_r;
  logic [7:0]         adr_r;
  logic [7:0]         osc_r;
  logic [7:0]         rdata_r;
  logic               en_r;
  logic               run_r;
  logic               aen_r;
  logic               flag_r;
  logic               flag_nxt;
  logic               set_r;
  logic               capq_r;
  logic               irq_r;
  logic               rst_r;
  logic               wake_r;

  // ===========================================
  // decode
  wire       wr_dat  = CE & CPU_REQ.dat_we;
  wire       rd_dat  = CE & CPU_REQ.dat_re;
  wire [7:0] wd      = CPU_REQ.wdata;
  wire       sel_cap = (adr_r < ADR_CTRL);
  wire [7:0] alm_off = adr_r - ADR_ALM0;
  wire       sel_alm = (adr_r >= ADR_ALM0) && (alm_off < 8'(BANK_BYTES));
  wire       sel_ctl = (adr_r == ADR_CTRL);
  wire       sel_osc = (adr_r == ADR_OSC);
  wire [5:0] cap_bit = {adr_r[2:0], 3'b000};
  wire [5:0] alm_bit = {alm_off[2:0], 3'b000};
  wire       wr_cap  = wr_dat & sel_cap;
  wire       wr_alm  = wr_dat & sel_alm;
  wire       wr_ctl  = wr_dat & sel_ctl;
  wire       wr_osc  = wr_dat & sel_osc;

  // ===========================================
  // alarm compare
  wire alarm_ge;
  rtc_ge_cmp #(
    .W (TIMER_W)
  ) u_cmp (
    .a  (timer_r),
    .b  (alm_r[BANK_W-1:1]),
    .ge (alarm_ge)
  ); // R8
  wire alarm_ev = aen_r & alarm_ge; // R9

  // set beats software clear
  assign flag_nxt = alarm_ev | (wr_ctl ? (flag_r & wd[B_FLAG]) : flag_r); // R17

  // preload first, else count with natural wrap
  assign timer_nxt = set_r ? cap_r[BANK_W-1:1] :               // R3 R4
                     run_r ? timer_r + 47'h0000_0000_0001 :    // R1 R18
                     timer_r;

  // ===========================================
  // read selection
  wire [7:0] ctl_val = {en_r, 2'b00, run_r, aen_r, flag_r, set_r, capq_r};
  wire [7:0] osc_val = {osc_r[B_GAIN:B_BIAS], OSC_VALID, 3'b000, BACKUP_PWR}; // R15 R16
  wire [7:0] rd_val  = sel_cap ? cap_r[cap_bit +: 8] :
                       sel_alm ? alm_r[alm_bit +: 8] :
                       sel_ctl ? ctl_val :
                       sel_osc ? osc_val :
                       BYTE_ZERO;

  // ===========================================
  // timer and control
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      timer_r <= TIMER_RST;
      en_r    <= 1'b0;
      run_r   <= 1'b0;
      aen_r   <= 1'b0;
      flag_r  <= 1'b0;
      set_r   <= 1'b0;
      capq_r  <= 1'b0;
    end
    else if (CE)
    begin
      timer_r <= timer_nxt; // R2
      flag_r  <= flag_nxt;
      set_r   <= wr_ctl & wd[B_SET]; // R5
      capq_r  <= wr_ctl & wd[B_CAP]; // R7
      if (wr_ctl)
      begin
        en_r  <= wd[B_EN];
        run_r <= wd[B_RUN];
        aen_r <= wd[B_AEN];
      end
    end
  end

  // ===========================================
  // capture and alarm banks
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      cap_r <= BANK_RST;
      alm_r <= BANK_RST;
    end
    else if (CE)
    begin
      if (capq_r)
        cap_r <= {timer_r, 1'b0}; // R6
      else if (wr_cap)
        cap_r[cap_bit +: 8] <= wd;
      if (wr_alm)
        alm_r[alm_bit +: 8] <= wd;
    end
  end

  // ===========================================
  // address, oscillator settings, read data
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      adr_r   <= BYTE_ZERO;
      osc_r   <= OSC_RST;
      rdata_r <= BYTE_ZERO;
    end
    else if (CE)
    begin
      if (CPU_REQ.adr_we)
        adr_r <= wd;
      if (wr_osc)
        osc_r <= {wd[B_GAIN:B_BIAS], 5'b00000}; // R16
      if (rd_dat)
        rdata_r <= rd_val;
    end
  end

  // ===========================================
  // requests
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      irq_r  <= 1'b0;
      rst_r  <= 1'b0;
      wake_r <= 1'b0;
    end
    else if (CE)
    begin
      irq_r  <= flag_nxt & IRQ_EN;     // R10
      rst_r  <= alarm_ev & RST_SRC_EN; // R11
      wake_r <= alarm_ev;              // R12
    end
  end

  assign ADR_Q        = adr_r;
  assign RDATA        = rdata_r;
  assign IRQ          = irq_r;
  assign RST_REQ      = rst_r;
  assign WAKE_REQ     = wake_r;
  assign GAIN_CTRL_EN = osc_r[B_GAIN];
  assign XTAL_MODE    = osc_r[B_CRYSTAL_MODE_SELECT];
  assign BIAS_DOUBLE  = osc_r[B_BIAS];

  // ===========================================
  // checks
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SRST);

  a_timer_counts: assert property (CE && run_r && !set_r |=> // R1 R18
    timer_r == $past(timer_r) + 47'h0000_0000_0001)
    else $error("timer did not advance by one");
  a_timer_holds: assert property (CE && !run_r && !set_r |=> $stable(timer_r)) // R1
    else $error("stopped timer changed");
  a_preload_copy: assert property (CE && set_r |=> // R4 R3 R2
    timer_r == $past(cap_r[BANK_W-1:1]))
    else $error("preload did not copy capture bank");
  a_set_clears: assert property (CE && wr_ctl && wd[B_SET] ##1 !(CE && wr_ctl) |=> !set_r) // R5
    else $error("set bit stuck after preload");
  a_capture_copy: assert property (CE && capq_r |=> cap_r == {$past(timer_r), 1'b0}) // R6
    else $error("snapshot not stored at bit 1");
  a_capture_clears: assert property (CE && capq_r && !wr_ctl |=> !capq_r) // R7
    else $error("capture bit stuck");
  a_alarm_flag: assert property (CE && aen_r && timer_r >= alm_r[BANK_W-1:1] |=> flag_r) // R9
    else $error("alarm flag not set on greater-or-equal");
  a_flag_sticky: assert property (CE && flag_r && !wr_ctl |=> flag_r) // R17
    else $error("alarm flag dropped without clear");
  a_wake_req: assert property (CE && alarm_ev |=> WAKE_REQ) // R12 R8
    else $error("no wake request on alarm");
  a_irq_req: assert property (CE && alarm_ev && IRQ_EN |=> IRQ) // R10
    else $error("no interrupt on alarm");
  a_reset_req: assert property (CE && alarm_ev && RST_SRC_EN |=> RST_REQ) // R11
    else $error("no reset request on alarm");
  a_freeze_state: assert property (!CE |=> // R1
    $stable(timer_r) && $stable(adr_r) && $stable(osc_r))
    else $error("state moved while clock enable low");
  a_backup_read: assert property (rd_dat && sel_osc |=> // R15
    RDATA[B_BACKUP] == $past(BACKUP_PWR) && RDATA[3:1] == 3'b000)
    else $error("backup status misread");

  c_alarm_event: cover property (CE && alarm_ev && IRQ_EN);
  c_preload: cover property (CE && set_r && run_r);
  c_capture: cover property (CE && capq_r ##1 rd_dat && sel_cap);
endmodule // rtc_timer_alarm_core

// file: verilog/rtc_pkg.sv
/*
  Constants and types shared by the real-time clock timer/alarm core.
  Assumes a single clock domain and the indirect address/data register pair.
*/
package rtc_pkg;

  // ===========================================
  // widths
  localparam int TIMER_W    = 47;
  localparam int BANK_W     = 48;
  localparam int BANK_BYTES = 6;

  // ===========================================
  // indirect register addresses
  localparam logic [7:0] ADR_CAP0 = 8'h00;
  localparam logic [7:0] ADR_CTRL = 8'h06;
  localparam logic [7:0] ADR_OSC  = 8'h07;
  localparam logic [7:0] ADR_ALM0 = 8'h08;

  // ===========================================
  // control register bit positions
  localparam int B_EN   = 7;
  localparam int B_RUN  = 4;
  localparam int B_AEN  = 3;
  localparam int B_FLAG = 2;
  localparam int B_SET  = 1;
  localparam int B_CAP  = 0;

  // ===========================================
  // oscillator control register bit positions
  localparam int B_GAIN   = 7;
  localparam int B_CRYSTAL_MODE_SELECT  = 6;
  localparam int B_BIAS   = 5;
  localparam int B_OSC_CLOCK_VALID = 4;
  localparam int B_BACKUP = 0;

  // ===========================================
  // values after reset
  localparam logic [BANK_W-1:0] BANK_RST  = 48'hffff_ffff_ffff;
  localparam logic [TIMER_W-1:0] TIMER_RST = 47'h0000_0000_0000;
  localparam logic [7:0]        OSC_RST   = 8'h00;
  localparam logic [7:0]        BYTE_ZERO = 8'h00;

  // ===========================================
  // processor access to the address/data pair
  typedef struct packed {
    logic       adr_we;
    logic       dat_we;
    logic       dat_re;
    logic [7:0] wdata;
  } rtc_req_s;

endpackage : rtc_pkg

// file: verilog/rtc_ge_cmp.sv
/*
  Unsigned greater-or-equal comparator.
  Assumes both operands are stable within the cycle.
*/
module rtc_ge_cmp #(
  parameter int W = 47
) (
  // operands
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  // result
  output wire logic         ge
);
  assign ge = (a >= b);
endmodule // rtc_ge_cmp

// file: tb/rtc_timer_alarm_core_tb.sv
/*
  Self-checking bench for the timer/alarm core, driven through the address/data pair.
  Assumes the core's package and a single 20 MHz clock; CE is dropped once to check freezing.
*/
module rtc_timer_alarm_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rtc_pkg::*;

  // ==========================================
  // stimulus and observation
  logic        ref_clk    = 1'b0;
  logic        srst       = 1'b1;
  logic        irq_en     = 1'b0;
  logic        rst_src_en = 1'b0;
  logic        osc_ok     = 1'b1;
  logic        backup     = 1'b0;
  logic        ce         = 1'b1;
  rtc_req_s    cpu_req    = '0;
  logic [7:0]  adr_q, rdata, d;
  logic        irq, rst_req, wake_req, gain, crystal_mode_select, bias;
  logic [47:0] v;
  logic [46:0] diff;
  logic [46:0] snap0;
  int          error_cnt  = 0;
  int          checks     = 0;
  int          cyc        = 0;

  rtc_timer_alarm_core i_dut (
    .REF_CLK(ref_clk), .SRST(srst), .CE(ce), .CPU_REQ(cpu_req), .ADR_Q(adr_q),
    .RDATA(rdata), .IRQ_EN(irq_en), .RST_SRC_EN(rst_src_en), .OSC_VALID(osc_ok),
    .BACKUP_PWR(backup), .IRQ(irq), .RST_REQ(rst_req), .WAKE_REQ(wake_req),
    .GAIN_CTRL_EN(gain), .XTAL_MODE(crystal_mode_select), .BIAS_DOUBLE(bias)
  );

  initial
  begin
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  // ==========================================
  // access tasks
  task automatic print_verdict;
    if (error_cnt == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic drive(input logic [2:0] s, input logic [7:0] w);
    @(posedge ref_clk);
    cpu_req <= {s, w};
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    drive(3'b100, a);
    drive(3'b010, w);
    drive(3'b000, 8'h00);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    drive(3'b100, a);
    drive(3'b001, 8'h00);
    drive(3'b000, 8'h00);
    @(negedge ref_clk);
    q = rdata;
  endtask

  task automatic wr_bank(input logic [7:0] base, input logic [47:0] val);
    for (int n = 0; n < BANK_BYTES; n++)
      wr(base + 8'(n), val[8*n +: 8]);
  endtask

  task automatic rd_bank(input logic [7:0] base, output logic [47:0] val);
    for (int n = 0; n < BANK_BYTES; n++)
    begin
      rd(base + 8'(n), d);
      val[8*n +: 8] = d;
    end
  endtask

  // write control, then poll until the self-clearing bit drops
  task automatic ctrl_cmd(input logic [7:0] w, input int b);
    wr(ADR_CTRL, w);
    for (int i = 0; i < 8; i++)
    begin
      rd(ADR_CTRL, d);
      if (d[b] === 1'b0)
        break;
    end
    chk("self-clearing bit", 48'h0, 48'(d[b]));
  endtask

  // load the timer (bank bit 0 set, must be ignored), then snapshot it
  task automatic load_snap(input logic [46:0] p, input logic [7:0] run);
    wr_bank(ADR_CAP0, {p, 1'b1});
    ctrl_cmd(run | 8'h02, B_SET);
    ctrl_cmd(run | 8'h01, B_CAP);
    rd_bank(ADR_CAP0, v);
    diff = v[47:1] - p;
  endtask

  task automatic alarm(input logic [46:0] a);
    wr(ADR_CTRL, 8'h00);
    wr_bank(ADR_ALM0, {a, 1'b1});
    wr(ADR_CTRL, 8'h08);
  endtask

  task automatic status(input logic [3:0] exp);
    repeat (2) @(posedge ref_clk);
    rd(ADR_CTRL, d);
    chk("flag wake irq reset", 48'(exp), 48'({d[B_FLAG], wake_req, irq, rst_req}));
  endtask

  // ==========================================
  // tests
  initial
  begin
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    rd(ADR_CAP0 + 8'h05, d);
    chk("capture reset", 48'hff, 48'(d));
    rd(ADR_ALM0, d);
    chk("alarm reset", 48'hff, 48'(d));
    rd(ADR_OSC, d);
    chk("osc reset", 48'h10, 48'(d));
    wr(8'h20, 8'h5a);
    rd(8'h20, d);
    chk("unmapped", 48'h0, 48'(d));
    chk("address", 48'h20, 48'(adr_q));
    wr(ADR_OSC, 8'hff);
    backup <= 1'b1;
    osc_ok <= 1'b0;
    rd(ADR_OSC, d);
    chk("osc readback", 48'he1, 48'(d));
    wr(ADR_OSC, 8'h40);
    @(negedge ref_clk);
    chk("osc outputs", 48'h2, 48'({gain, crystal_mode_select, bias}));
    load_snap(47'h5a5a_1234_c3c3, 8'h00);
    chk("preload snapshot", {47'h5a5a_1234_c3c3, 1'b0}, v);
    load_snap(47'h0000_0000_1000, 8'h10);
    chk("running count", 48'd5, 48'(diff));
    // freeze 40 edges, with a write that must be ignored
    snap0 = v[47:1];
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(ADR_OSC, 8'h20);
    repeat (37) @(posedge ref_clk);
    ce <= 1'b1;
    chk("frozen address", 48'h05, 48'(adr_q));
    chk("frozen osc", 48'h2, 48'({gain, crystal_mode_select, bias}));
    ctrl_cmd(8'h11, B_CAP);
    rd_bank(ADR_CAP0, v);
    diff = v[47:1] - snap0;
    chk("frozen count", 48'd25, 48'(diff));
    load_snap(47'h7fff_ffff_fffc, 8'h10);
    chk("wrap", 48'h1, 48'(v[47:1]));
    load_snap(47'h0000_0000_0100, 8'h00);
    alarm(47'h100);
    status(4'b1100);
    @(posedge ref_clk);
    irq_en <= 1'b1;
    rst_src_en <= 1'b1;
    status(4'b1111);
    alarm(47'h101);
    status(4'b0000);
    alarm(47'h0ff);
    status(4'b1111);
    wr_bank(ADR_ALM0, BANK_RST);
    status(4'b1010);
    wr(ADR_CTRL, 8'h88);
    status(4'b0000);
    chk("control readback", 48'h88, 48'(d));
    print_verdict();
  end
endmodule // rtc_timer_alarm_core_tb
